// [common/rsq_map.svh]
// Offsets, reset values and timing counts of the reset sequencer
`ifndef RSQ_MAP_SVH
`define RSQ_MAP_SVH

// Register port offsets
`define RSQ_OFS_CAUSE    4'h0
`define RSQ_OFS_STATE    4'h1
`define RSQ_OFS_CNT_HI   4'h2
`define RSQ_OFS_CNT_LO   4'h3

// Cause register bit positions
`define RSQ_CAUSE_EXT    0
`define RSQ_CAUSE_WDT    1
`define RSQ_CAUSE_STOP   2
`define RSQ_CAUSE_HALT   3

// Reset vector table
`define RSQ_VEC_LO_ADDR  16'h0000
`define RSQ_VEC_HI_ADDR  16'h0001

// Settle wait: 2**15 periods of the system clock
`define RSQ_SETTLE_EXP   15
`define RSQ_SETTLE_CYC   (1 << `RSQ_SETTLE_EXP)
// Cycles a watchdog reset stays asserted before it releases itself
`define RSQ_WDT_HOLD_CYC 3'h4

// Post-reset register values
`define RSQ_RV_STATUS    8'h02
`define RSQ_RV_PORT_LAT  8'h00
`define RSQ_RV_PORT_DIR  8'hFF
`define RSQ_RV_PULLUP    8'h00
`define RSQ_RV_DRIVE     8'h00
`define RSQ_RV_CLK_CTRL  8'h02
`define RSQ_RV_OSC_SEL   8'h04
`define RSQ_RV_TMR_CNT   8'h00
`define RSQ_RV_TMR_MODE  8'h00
`define RSQ_RV_WDT_CLK   8'h00
`define RSQ_RV_WDT_MODE  8'h00
`define RSQ_RV_USB_RXCNT 8'h18
`define RSQ_RV_USB_TXCA  8'h20
`define RSQ_RV_USB_TXCB  8'h30
`define RSQ_RV_USB_TMR   8'h01
`define RSQ_RV_USB_WAKE  8'h08
`define RSQ_RV_USB_PIDC  8'hC3
`define RSQ_RV_USB_CLR   8'h00
`define RSQ_RV_SER_MODE  8'h00
`define RSQ_RV_IRQ_REQ   8'h00
`define RSQ_RV_IRQ_MASK  8'hFF
`define RSQ_RV_EXT_EDGE  8'h00
`define RSQ_RV_KEY_WAKE  8'h00

`endif

// [common/rsq_pkg.sv]
// Types shared by the reset sequencer modules
package rsq_pkg;

	typedef enum logic [2:0] {
		RSQ_ASSERT,
		RSQ_SETTLE,
		RSQ_FETCH_LO,
		RSQ_FETCH_HI,
		RSQ_LOAD,
		RSQ_RUN
	} rsq_state_e;

	// Values that peripherals take when the sequence completes
	typedef struct packed {
		logic [7:0] processor_status_word;
		logic [7:0] port_latch;
		logic [7:0] port_direction;
		logic [7:0] pullup_option;
		logic [7:0] port_drive_type;
		logic [7:0] cpu_clock_control;
		logic [7:0] osc_settle_select;
		logic [7:0] timer_count;
		logic [7:0] timer_mode_control;
		logic [7:0] watchdog_clock_select;
		logic [7:0] watchdog_mode;
		logic [7:0] usb_rx_byte_counter;
		logic [7:0] usb_tx_byte_counter_a;
		logic [7:0] usb_tx_byte_counter_b;
		logic [7:0] usb_timer_reservation;
		logic [7:0] usb_remote_wakeup_ctrl;
		logic [7:0] usb_pid_compare;
		logic [7:0] usb_clear_value;
		logic [7:0] serial_mode;
		logic [7:0] irq_request_flags;
		logic [7:0] irq_mask_flags;
		logic [7:0] ext_irq_edge_mode;
		logic [7:0] key_wake_mode;
	} rsq_defaults_s;

	// Program counter hand-off to the processor
	typedef struct packed {
		logic        load;
		logic        valid;
		logic [15:0] value;
	} rsq_pc_s;

endpackage : rsq_pkg

// [logic/rsq_sync.sv]
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module rsq_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_reg;

	// Reset value low: an unknown pin reads as reset asserted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : rsq_sync

// [logic/rsq_settle_counter.sv]
// Counter of the oscillation settle wait
`timescale 1ns/1ps
module rsq_settle_counter #(
	parameter int unsigned CYCLES = 32768
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clear,
	input  wire logic        run,
	output logic [14:0]      count,
	output logic             done
);
	localparam logic [14:0] LAST = 15'(CYCLES - 1);

	logic at_last;
	assign at_last = (count == LAST);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 15'h0000;
			done  <= 1'b0;
		end else if (clear) begin
			count <= 15'h0000;
			done  <= 1'b0;
		end else if (run && !done) begin
			count <= at_last ? count : count + 15'h0001;
			done  <= at_last;
		end
	end
endmodule : rsq_settle_counter

// [logic/rsq_reset_sequencer.sv]
// System reset sequencer: sources, settle wait, vector fetch, defaults
//
// Behaviour
// RULE_01: Reset comes from a low reset pin or from a watchdog overflow.
// RULE_02: Both sources act alike; execution starts from vector at 0000H/0001H.
// RULE_03: Pins are high impedance during reset and the settle wait after it.
// RULE_04: Pin high releases reset; execution waits 2^15 clock periods first.
// RULE_05: Watchdog reset releases itself, then takes the same settle wait.
// RULE_06: The external source holds the pin low at least 10 microseconds.
// RULE_07: Reset out of STOP keeps STOP contents; only port pins float (the code floats pins_hiz with port_pins_hiz on every reset).
// RULE_08: During reset only the program counter is undefined; then vector loads.
// RULE_09: RAM is undefined after reset, but retained if reset hits standby.
// RULE_10: Stack pointer is left undefined; status word becomes 02H.
// RULE_11: Port latches, pull-ups, drive types clear; port directions set to FFH.
// RULE_12: Clock control becomes 02H; settle select becomes 04H.
// RULE_13: Timer counters, timer modes and watchdog registers clear; compares untouched.
// RULE_14: USB byte counters preset to 18H, 20H and 30H.
// RULE_15: USB timer reservation 01H, remote wakeup 08H, PID compare C3H.
// RULE_16: Other USB control registers clear; USB buffers stay undefined.
// RULE_17: Interrupt requests and modes clear; all interrupt masks set.
// RULE_18: Serial mode clears; serial shift register stays undefined.
// RULE_19: Reset during HALT releases HALT and takes the reset vector.
// RULE_20: Reset pin is synchronised; settle wait uses a 15-bit counter.
// RULE_21: A reset during the settle wait restarts the sequence.
`timescale 1ns/1ps
`include "rsq_map.svh"

module rsq_reset_sequencer
	import rsq_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = `RSQ_SETTLE_CYC
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          reset_pin_n,
	input  wire logic          wdt_overflow,
	input  wire logic          cpu_halt,
	input  wire logic          cpu_stop,
	output logic               vec_rd,
	output logic [15:0]        vec_addr,
	input  wire logic [7:0]    vec_data,
	output logic               sys_rst_n,
	output logic               pins_hiz,
	output logic               port_pins_hiz,
	output logic               periph_hold,
	output logic               cpu_run,
	output logic               halt_release,
	output logic               ram_retain,
	output logic               defaults_load,
	output rsq_defaults_s      defaults,
	output rsq_pc_s            pc,
	input  wire logic [3:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic [7:0]         reg_rdata
);

	////////////////////////////////////////////////////////////////////////
	// Reset sources

	logic       pin_sync;
	logic       ext_req;
	logic       wdt_req;
	logic       any_req;
	logic [2:0] wdt_hold_reg;
	logic [2:0] wdt_hold_next;
	logic       hold_busy;

	rsq_sync u_pin_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (reset_pin_n),
		.sync_out (pin_sync)
	);

	assign ext_req = ~pin_sync;                   // RULE_01 RULE_20
	assign wdt_req = wdt_overflow;                // RULE_01
	assign any_req = ext_req | wdt_req;           // RULE_02
	assign hold_busy = (wdt_hold_reg != 3'h0);

	// A watchdog pulse holds reset a few cycles, then lets go by itself
	assign wdt_hold_next = wdt_req   ? `RSQ_WDT_HOLD_CYC :
	                       hold_busy ? wdt_hold_reg - 3'h1 :
	                                   3'h0;     // RULE_05

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_hold_reg <= 3'h0;
		end else begin
			wdt_hold_reg <= wdt_hold_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Settle wait counter

	logic        cnt_clear;
	logic        cnt_run;
	logic [14:0] cnt_value;
	logic        cnt_done;

	rsq_settle_counter #(
		.CYCLES (SETTLE_CYCLES)
	) u_settle (
		.clk   (clk),
		.rst_n (rst_n),
		.clear (cnt_clear),
		.run   (cnt_run),
		.count (cnt_value),
		.done  (cnt_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequence state

	rsq_state_e state_reg;
	rsq_state_e state_next;
	logic       in_assert;
	logic       in_settle;
	logic       in_reset;
	logic       release_ok;
	logic       enter_reset;

	assign in_assert  = (state_reg == RSQ_ASSERT);
	assign in_settle  = (state_reg == RSQ_SETTLE);
	assign in_reset   = (state_reg != RSQ_RUN);
	assign release_ok = ~ext_req & ~hold_busy;   // RULE_04 RULE_05
	assign enter_reset = any_req & ~in_assert;

	// Counter restarts whenever the sequence is back at assertion
	assign cnt_clear = in_assert | any_req;      // RULE_21
	assign cnt_run   = in_settle;                // RULE_04 RULE_20

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			RSQ_ASSERT: begin
				if (release_ok && !wdt_req) begin
					state_next = RSQ_SETTLE;
				end
			end
			RSQ_SETTLE: begin
				if (any_req) begin
					state_next = RSQ_ASSERT;   // RULE_21
				end else if (cnt_done) begin
					state_next = RSQ_FETCH_LO; // RULE_04
				end
			end
			RSQ_FETCH_LO: begin
				state_next = any_req ? RSQ_ASSERT : RSQ_FETCH_HI;
			end
			RSQ_FETCH_HI: begin
				state_next = any_req ? RSQ_ASSERT : RSQ_LOAD;
			end
			RSQ_LOAD: begin
				state_next = any_req ? RSQ_ASSERT : RSQ_RUN;
			end
			RSQ_RUN: begin
				if (any_req) begin
					state_next = RSQ_ASSERT;   // RULE_01 RULE_19
				end
			end
			default: begin
				state_next = RSQ_ASSERT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= RSQ_ASSERT;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset vector fetch

	logic        fetch_lo;
	logic        fetch_hi;
	logic        vec_rd_next;
	logic [15:0] vec_addr_next;
	logic [7:0]  vec_lo_reg;
	logic [15:0] pc_value_next;

	// Vector memory answers one cycle after the read strobe
	assign fetch_lo = (state_next == RSQ_FETCH_LO) & ~any_req;
	assign fetch_hi = (state_next == RSQ_FETCH_HI) & ~any_req;
	assign vec_rd_next = fetch_lo | fetch_hi;                    // RULE_02
	assign vec_addr_next = fetch_hi ? `RSQ_VEC_HI_ADDR
	                                : `RSQ_VEC_LO_ADDR;           // RULE_02
	assign pc_value_next = {vec_data, vec_lo_reg};               // RULE_08

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vec_lo_reg <= 8'h00;
		end else if (state_reg == RSQ_FETCH_HI) begin
			vec_lo_reg <= vec_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Standby capture

	logic from_stop_reg;
	logic from_halt_reg;
	logic stop_hit;
	logic halt_hit;

	assign stop_hit = enter_reset & cpu_stop & ~in_reset;
	assign halt_hit = enter_reset & cpu_halt & ~in_reset;

	// Remembered for the whole sequence; a reset from run mode clears them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			from_stop_reg <= 1'b0;
			from_halt_reg <= 1'b0;
		end else if (enter_reset && state_reg == RSQ_RUN) begin
			from_stop_reg <= cpu_stop;                   // RULE_07
			from_halt_reg <= cpu_halt;                   // RULE_19
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output flops

	logic in_reset_next;
	logic hiz_next;
	logic load_next;
	logic retain_next;

	assign in_reset_next = (state_next != RSQ_RUN);
	// Pins float through assertion and settle wait, released for the fetch
	assign hiz_next = (state_next == RSQ_ASSERT) |
	                  (state_next == RSQ_SETTLE);          // RULE_03
	assign load_next = (state_reg == RSQ_LOAD) & ~any_req;  // RULE_08
	// Power-on leaves RAM undefined; a standby entry keeps it
	assign retain_next = from_stop_reg | from_halt_reg;   // RULE_07 RULE_09

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_rst_n     <= 1'b0;
			pins_hiz      <= 1'b1;
			port_pins_hiz <= 1'b1;
			periph_hold   <= 1'b1;
			cpu_run       <= 1'b0;
			halt_release  <= 1'b0;
			ram_retain    <= 1'b0;
			defaults_load <= 1'b0;
			vec_rd        <= 1'b0;
			vec_addr      <= `RSQ_VEC_LO_ADDR;
			pc            <= '0;
		end else begin
			sys_rst_n     <= ~in_reset_next;            // RULE_02
			pins_hiz      <= hiz_next;                  // RULE_03
			port_pins_hiz <= hiz_next;                  // RULE_07
			// Peripherals keep their contents until the sequence completes
			periph_hold   <= in_reset_next;             // RULE_07 RULE_08
			cpu_run       <= ~in_reset_next;            // RULE_04
			halt_release  <= halt_hit;                  // RULE_19
			ram_retain    <= retain_next;               // RULE_09
			defaults_load <= load_next;                 // RULE_08
			vec_rd        <= vec_rd_next;
			vec_addr      <= vec_addr_next;
			pc.load       <= load_next;                 // RULE_08
			// Program counter counts as undefined while in reset
			pc.valid      <= load_next | (pc.valid & ~in_reset_next);
			if (load_next) begin
				pc.value <= pc_value_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Post-reset values; stack pointer, compares, serial shift register
	// and USB data buffers are not driven, so they stay as they were

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			defaults.processor_status_word  <= `RSQ_RV_STATUS;   // RULE_10
			defaults.port_latch             <= `RSQ_RV_PORT_LAT; // RULE_11
			defaults.port_direction         <= `RSQ_RV_PORT_DIR; // RULE_11
			defaults.pullup_option          <= `RSQ_RV_PULLUP;   // RULE_11
			defaults.port_drive_type        <= `RSQ_RV_DRIVE;    // RULE_11
			defaults.cpu_clock_control      <= `RSQ_RV_CLK_CTRL; // RULE_12
			defaults.osc_settle_select      <= `RSQ_RV_OSC_SEL;  // RULE_12
			defaults.timer_count            <= `RSQ_RV_TMR_CNT;  // RULE_13
			defaults.timer_mode_control     <= `RSQ_RV_TMR_MODE; // RULE_13
			defaults.watchdog_clock_select  <= `RSQ_RV_WDT_CLK;  // RULE_13
			defaults.watchdog_mode          <= `RSQ_RV_WDT_MODE; // RULE_13
			defaults.usb_rx_byte_counter    <= `RSQ_RV_USB_RXCNT; // RULE_14
			defaults.usb_tx_byte_counter_a  <= `RSQ_RV_USB_TXCA; // RULE_14
			defaults.usb_tx_byte_counter_b  <= `RSQ_RV_USB_TXCB; // RULE_14
			defaults.usb_timer_reservation  <= `RSQ_RV_USB_TMR;  // RULE_15
			defaults.usb_remote_wakeup_ctrl <= `RSQ_RV_USB_WAKE; // RULE_15
			defaults.usb_pid_compare        <= `RSQ_RV_USB_PIDC; // RULE_15
			defaults.usb_clear_value        <= `RSQ_RV_USB_CLR;  // RULE_16
			defaults.serial_mode            <= `RSQ_RV_SER_MODE; // RULE_18
			defaults.irq_request_flags      <= `RSQ_RV_IRQ_REQ;  // RULE_17
			defaults.irq_mask_flags         <= `RSQ_RV_IRQ_MASK; // RULE_17
			defaults.ext_irq_edge_mode      <= `RSQ_RV_EXT_EDGE; // RULE_17
			defaults.key_wake_mode          <= `RSQ_RV_KEY_WAKE; // RULE_17
		end else begin
			defaults <= defaults;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port

	logic [3:0] cause_reg;
	logic [3:0] cause_set;
	logic [3:0] cause_clr;
	logic [3:0] cause_next;
	logic       sel_cause;
	logic       sel_state;
	logic       sel_cnt_hi;
	logic       sel_cnt_lo;
	logic [7:0] rd_mux;

	assign sel_cause  = (reg_addr == `RSQ_OFS_CAUSE);
	assign sel_state  = (reg_addr == `RSQ_OFS_STATE);
	assign sel_cnt_hi = (reg_addr == `RSQ_OFS_CNT_HI);
	assign sel_cnt_lo = (reg_addr == `RSQ_OFS_CNT_LO);

	// Write one clears; a cause landing in the same cycle survives
	assign cause_set[`RSQ_CAUSE_EXT]  = ext_req & ~in_assert;
	assign cause_set[`RSQ_CAUSE_WDT]  = wdt_req;
	assign cause_set[`RSQ_CAUSE_STOP] = stop_hit;
	assign cause_set[`RSQ_CAUSE_HALT] = halt_hit;
	assign cause_clr  = (reg_wr && sel_cause) ? reg_wdata[3:0] : 4'h0;
	assign cause_next = (cause_reg & ~cause_clr) | cause_set;

	assign rd_mux = sel_cause  ? {4'h0, cause_reg} :
	                sel_state  ? {cnt_done, 4'h0, state_reg} :
	                sel_cnt_hi ? {1'b0, cnt_value[14:8]} :
	                sel_cnt_lo ? cnt_value[7:0] :
	                             8'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_reg <= 4'h0;
			reg_rdata <= 8'h00;
		end else begin
			cause_reg <= cause_next;
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

endmodule : rsq_reset_sequencer

// [test/rsq_reset_sequencer_assertions.sv]
// Concurrent checks on the reset sequencer ports
`timescale 1ns/1ps
module rsq_reset_sequencer_checker
	import rsq_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = 32768
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          wdt_overflow,
	input  wire logic          vec_rd,
	input  wire logic [15:0]   vec_addr,
	input  wire logic [7:0]    vec_data,
	input  wire logic          sys_rst_n,
	input  wire logic          pins_hiz,
	input  wire logic          port_pins_hiz,
	input  wire logic          periph_hold,
	input  wire logic          cpu_run,
	input  wire logic          halt_release,
	input  wire logic          defaults_load,
	input  wire rsq_defaults_s defaults,
	input  wire rsq_pc_s       pc,
	input  wire logic          reg_rd,
	input  wire logic [7:0]    reg_rdata
);
	localparam rsq_defaults_s DEF_EXP = 184'h0200FF00000204000000001820300108C3000000FF0000;

	logic [15:0] low_cnt;
	logic [15:0] low_next;
	logic        rd_d;
	logic [15:0] addr_d;
	logic [7:0]  lo_seen;
	logic [7:0]  hi_seen;
	logic        lo_take;
	logic        hi_take;

	////////////////////////////////////////////////////////////////////////////////
	// Cycles without execution, saturating so a long pin hold cannot wrap it
	assign low_next = cpu_run ? 16'h0000 : (&low_cnt ? low_cnt : low_cnt + 16'h0001);
	assign lo_take  = rd_d && (addr_d == 16'h0000);
	assign hi_take  = rd_d && (addr_d == 16'h0001);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= 16'h0000;
			rd_d    <= 1'b0;
			addr_d  <= 16'h0000;
		end else begin
			low_cnt <= low_next;
			rd_d    <= vec_rd;
			addr_d  <= vec_addr;
		end
	end

	// Vector bytes as the memory returned them, one cycle after each strobe
	always_ff @(posedge clk) begin
		lo_seen <= lo_take ? vec_data : lo_seen;
		hi_seen <= hi_take ? vec_data : hi_seen;
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence fetch_lo_s;
		vec_rd && (vec_addr == 16'h0000);
	endsequence
	sequence fetch_hi_s;
		vec_rd && (vec_addr == 16'h0001);
	endsequence
	sequence load_s;
		pc.load && defaults_load && pc.valid && cpu_run;
	endsequence

	vec_order_a: assert property (fetch_lo_s |=> fetch_hi_s)
		else $error("vector high byte not fetched after low byte");
	load_join_a: assert property ($rose(cpu_run) |-> load_s)
		else $error("execution started without pc and defaults load");
	pc_vector_a: assert property (pc.load |-> pc.value == {hi_seen, lo_seen})
		else $error("pc not loaded from vector bytes");
	settle_len_a: assert property ($rose(cpu_run) |-> 32'(low_cnt) >= SETTLE_CYCLES)
		else $error("execution before settle wait elapsed");
	hiz_settle_a: assert property ($fell(pins_hiz) |-> 32'(low_cnt) >= SETTLE_CYCLES)
		else $error("pins left high impedance before settle wait");
	hiz_pair_a: assert property (pins_hiz |-> !cpu_run && port_pins_hiz)
		else $error("pins float state inconsistent");
	hold_span_a: assert property (!sys_rst_n |-> periph_hold)
		else $error("peripherals not held during reset");
	run_level_a: assert property (cpu_run == sys_rst_n)
		else $error("run flag disagrees with system reset");
	wdt_entry_a: assert property (wdt_overflow |-> ##[1:2] !sys_rst_n)
		else $error("watchdog overflow did not assert reset");
	defaults_val_a: assert property (defaults_load |-> defaults == DEF_EXP)
		else $error("post-reset values wrong at load");
	halt_exit_a: assert property (halt_release |-> ##[0:2] !sys_rst_n)
		else $error("halt release without reset");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
endmodule : rsq_reset_sequencer_checker

bind rsq_reset_sequencer rsq_reset_sequencer_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
	.clk(clk), .rst_n(rst_n), .wdt_overflow(wdt_overflow), .vec_rd(vec_rd),
	.vec_addr(vec_addr), .vec_data(vec_data), .sys_rst_n(sys_rst_n), .pins_hiz(pins_hiz),
	.port_pins_hiz(port_pins_hiz), .periph_hold(periph_hold), .cpu_run(cpu_run),
	.halt_release(halt_release), .defaults_load(defaults_load), .defaults(defaults),
	.pc(pc), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// [test/rsq_far_model.sv]
// Far-side model: reset pin source, watchdog overflow source and vector memory
`timescale 1ns/1ps
module rsq_far_model #(
	parameter logic [7:0] VEC_LO = 8'h5A,
	parameter logic [7:0] VEC_HI = 8'hA5
) (
	input  wire logic        clk,
	input  wire logic        vec_rd,
	input  wire logic [15:0] vec_addr,
	output logic [7:0]       vec_data,
	output logic             reset_pin_n,
	output logic             wdt_overflow
);
	// 10 us at the 8 ns clock; shorter requests are stretched, not refused
	localparam int MIN_LOW = 1250;

	initial begin
		vec_data = 8'h00;
		reset_pin_n = 1'b1;
		wdt_overflow = 1'b0;
	end

	// Data only valid the cycle after a strobe; it toggles otherwise so stale use shows
	always @(posedge clk) begin
		if (vec_rd && vec_addr == 16'h0000) vec_data <= VEC_LO;
		else if (vec_rd && vec_addr == 16'h0001) vec_data <= VEC_HI;
		else vec_data <= ~vec_data;
	end

	task automatic pin_low(input int n);
		@(posedge clk) reset_pin_n <= 1'b0;
		repeat ((n < MIN_LOW) ? MIN_LOW : n) @(posedge clk);
		reset_pin_n <= 1'b1;
	endtask : pin_low

	task automatic wdt_pulse();
		@(posedge clk) wdt_overflow <= 1'b1;
		@(posedge clk) wdt_overflow <= 1'b0;
	endtask : wdt_pulse
endmodule : rsq_far_model

// [test/tb.sv]
// Self-checking bench of the reset sequencer
`timescale 1ns/1ps
module tb
	import rsq_pkg::*;
;
	localparam int unsigned SETTLE = 8;
	localparam logic [15:0] VEC = 16'hA55A;
	localparam rsq_defaults_s DEF_EXP = 184'h0200FF00000204000000001820300108C3000000FF0000;

	logic          clk, rst_n, reset_pin_n, wdt_overflow, cpu_halt, cpu_stop;
	logic          vec_rd, sys_rst_n, pins_hiz, port_pins_hiz, periph_hold, cpu_run;
	logic          halt_release, ram_retain, defaults_load, reg_wr, reg_rd;
	logic [15:0]   vec_addr;
	logic [7:0]    vec_data, reg_wdata, reg_rdata, d;
	logic [3:0]    reg_addr;
	rsq_defaults_s defaults;
	rsq_pc_s       pc;
	logic          halt_seen;
	int            bad_count, samples_checked, cycles;

	rsq_reset_sequencer #(.SETTLE_CYCLES(SETTLE)) dut (
		.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .wdt_overflow(wdt_overflow),
		.cpu_halt(cpu_halt), .cpu_stop(cpu_stop), .vec_rd(vec_rd), .vec_addr(vec_addr),
		.vec_data(vec_data), .sys_rst_n(sys_rst_n), .pins_hiz(pins_hiz),
		.port_pins_hiz(port_pins_hiz), .periph_hold(periph_hold), .cpu_run(cpu_run),
		.halt_release(halt_release), .ram_retain(ram_retain), .defaults_load(defaults_load),
		.defaults(defaults), .pc(pc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);

	rsq_far_model #(.VEC_LO(VEC[7:0]), .VEC_HI(VEC[15:8])) u_far (
		.clk(clk), .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_data(vec_data),
		.reset_pin_n(reset_pin_n), .wdt_overflow(wdt_overflow)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic reg_read(input logic [3:0] a, output logic [7:0] data);
		@(posedge clk) reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk) reg_rd <= 1'b0;
		#1 data = reg_rdata;
	endtask : reg_read

	task automatic reg_write(input logic [3:0] a, input logic [7:0] w);
		@(posedge clk) reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge clk) reg_wr <= 1'b0;
	endtask : reg_write

	// Waits for execution to start and checks the hand-over state
	task automatic wait_run(input int min);
		int n;
		n = 0;
		while (cpu_run !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("settle wait length", 16'h0001, 16'(n >= min && n < 3000));
		chk("pc value", VEC, pc.value);
		chk("pc valid", 16'h0001, 16'(pc.valid));
		chk("pins float after run", 16'h0000, 16'(pins_hiz));
		chk("system reset after run", 16'h0001, 16'(sys_rst_n));
	endtask : wait_run

	always @(posedge clk) begin
		if (halt_release === 1'b1) halt_seen <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		cpu_halt = 1'b0;
		cpu_stop = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		halt_seen = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (5) @(posedge clk);
		#1 chk("pins float in reset", 16'h0001, 16'(pins_hiz));
		chk("system reset in reset", 16'h0000, 16'(sys_rst_n));
		samples_checked++;
		if (defaults !== DEF_EXP) begin
			bad_count++;
			$display("MISMATCH defaults expected %h seen %h", DEF_EXP, defaults);
		end
		@(posedge clk) rst_n <= 1'b1;
		wait_run(SETTLE);
		reg_read(4'h1, d);
		chk("state run", 16'h0005, 16'(d[2:0]));
		chk("settle done flag", 16'h0001, 16'(d[7]));
		reg_write(4'h1, 8'h00);
		reg_read(4'h1, d);
		chk("state after ignored write", 16'h0005, 16'(d[2:0]));
		reg_read(4'hF, d);
		chk("unmapped read", 16'h0000, 16'(d));
		reg_write(4'h0, 8'h0F);
		// Pin reset while halted
		@(posedge clk) cpu_halt <= 1'b1;
		u_far.pin_low(1250);
		#1 chk("pin reset held", 16'h0000, 16'(sys_rst_n));
		chk("pins float after pin release", 16'h0001, 16'(pins_hiz));
		chk("halt released", 16'h0001, 16'(halt_seen));
		wait_run(SETTLE);
		chk("retain after halt reset", 16'h0001, 16'(ram_retain));
		reg_read(4'h0, d);
		chk("pin cause", 16'h0001, 16'(d[0]));
		reg_write(4'h0, 8'h0F);
		reg_read(4'h0, d);
		chk("cause cleared", 16'h0000, 16'(d[3:0]));
		// Watchdog reset out of STOP
		@(posedge clk) cpu_halt <= 1'b0;
		cpu_stop <= 1'b1;
		u_far.wdt_pulse();
		repeat (2) @(posedge clk);
		#1 chk("watchdog reset entry", 16'h0000, 16'(cpu_run));
		chk("port pins float", 16'h0001, 16'(port_pins_hiz));
		wait_run(SETTLE);
		chk("retain after stop reset", 16'h0001, 16'(ram_retain));
		reg_read(4'h0, d);
		chk("watchdog and stop cause", 16'h0006, 16'(d[2:0] & 3'h6));
		@(posedge clk) cpu_stop <= 1'b0;
		// Second overflow in mid settle restarts the sequence
		u_far.wdt_pulse();
		repeat (9) @(posedge clk);
		u_far.wdt_pulse();
		wait_run(SETTLE + 4);
		chk("no retain after run reset", 16'h0000, 16'(ram_retain));
		reg_read(4'h3, d);
		chk("settle count low", 16'(SETTLE - 1), 16'(d));
		reg_read(4'h2, d);
		chk("settle count high", 16'h0000, 16'(d));
		end_of_test();
	end
endmodule : tb
